// ---- design/lfw_pkg.sv ----
// Package for the line fault and wake-up host controller.
// Holds the register map, field positions, reset values and timing counts.
// Assumes a 100 MHz block clock; every count is derived from a time in ns.
package lfw_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [3:0] LFW_OFS_CTRL   = 4'h0;
    localparam logic [3:0] LFW_OFS_STATUS = 4'h4;
    localparam logic [3:0] LFW_OFS_CMD    = 4'h8;
    localparam logic [3:0] LFW_OFS_LIMIT  = 4'hc;

    // Control register fields.
    localparam int LFW_CTRL_MAIN_EN   = 0;
    localparam int LFW_CTRL_AUX_EN    = 1;
    localparam int LFW_CTRL_MAIN_TX   = 2;
    localparam int LFW_CTRL_AUX_TX    = 3;
    localparam int LFW_CTRL_SLEW      = 4;
    localparam int LFW_CTRL_AUTO_DIS  = 5;
    localparam int LFW_CTRL_AUTO_ACK  = 6;
    localparam int LFW_CTRL_W         = 7;
    localparam logic [6:0] LFW_CTRL_RST = 7'h00;

    // Command register fields, write-one pulses.
    localparam int LFW_CMD_ACK        = 0;
    localparam int LFW_CMD_START_DONE = 1;
    localparam int LFW_CMD_LINK_OK    = 2;

    // Status register fields.
    localparam int LFW_ST_SHORT       = 0;
    localparam int LFW_ST_CONF        = 2;
    localparam int LFW_ST_THERMAL     = 4;
    localparam int LFW_ST_WAKE        = 5;
    localparam int LFW_ST_AUX_READY   = 6;
    localparam int LFW_ST_HOLD        = 7;
    localparam int LFW_ST_IGNORED     = 8;
    localparam int LFW_ST_RX          = 9;
    localparam int LFW_ST_BUSY        = 10;
    localparam int LFW_ST_COUNT       = 12;

    // Wake event limit register.
    localparam logic [3:0] LFW_LIMIT_RST = 4'h3;

    // Timing, each time as printed and its cycle count at the block clock.
    localparam int CLK_PERIOD_NS    = 10;
    localparam int FLAG_FILT_NS     = 80000;
    localparam int FLAG_FILT_CYC    =
        (FLAG_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AUX_LEAD_NS      = 3000000;
    localparam int AUX_LEAD_CYC     =
        (AUX_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_CONFIRM_NS = 20000000;
    localparam int SHORT_CONFIRM_CYC =
        (SHORT_CONFIRM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_STEP_NS      = 2000;
    localparam int ACK_STEP_CYC     =
        (ACK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int LFW_CNT_W = 24;

    // Wake acknowledge handshake states.
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_DROP,
        HS_TOGGLE
    } lfw_hs_state_t;

endpackage

// ---- design/lfw_filt_if.sv ----
// Interface between the controller and its short flag filter.
// Carries the raw active-low flags in and the filtered flags out.
interface lfw_filt_if;
    logic       ce;
    logic [1:0] raw_n;
    logic [1:0] filt_n;

    modport ctl (output ce, output raw_n, input filt_n);
    modport flt (input ce, input raw_n, output filt_n);
endinterface

// ---- design/lfw_flag_filter.sv ----
// Two-channel debounce for the active-low short flags.
// Assumes the raw flags are already synchronous to ref_clk_i.
module lfw_flag_filter
    import lfw_pkg::*;
#(
    parameter int FILT_CYC = FLAG_FILT_CYC
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    lfw_filt_if.flt   fif
);

    logic [LFW_CNT_W-1:0] cnt_ff [2];
    logic [1:0]           filt_ff;
    logic [1:0]           hit;

    assign fif.filt_n = filt_ff;

    // A flag follows the raw level only once it has stood for FILT_CYC
    // cycles, so reflection spikes at each drive pulse are swallowed.
    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign hit[c] = (cnt_ff[c] == LFW_CNT_W'(FILT_CYC - 1));

        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                cnt_ff[c]  <= '0;
                filt_ff[c] <= 1'b1;
            end else if (fif.ce) begin
                if (fif.raw_n[c] == filt_ff[c] || hit[c]) begin
                    cnt_ff[c] <= '0;
                end else begin
                    cnt_ff[c] <= cnt_ff[c] + 1'b1;
                end
                if (hit[c] && fif.raw_n[c] != filt_ff[c]) begin
                    filt_ff[c] <= fif.raw_n[c];
                end
            end
        end

        property p_filt_stable;
            @(posedge ref_clk_i) disable iff (rst_i)
            $changed(filt_ff[c]) |->
                $past(cnt_ff[c]) == LFW_CNT_W'(FILT_CYC - 1);
        endproperty
        a_filt_stable: assert property (p_filt_stable)
            else $error("Flag filter output moved before the hold time.");
    end

endmodule

// ---- design/lfw_host_ctrl.sv ----
// Host controller for a two-driver line transceiver with fault and wake.
// Drives the enable and data pins, filters and times the short flags and
// acknowledges wake requests; software reaches it over Avalon-MM.
// Assumes all pin inputs are synchronous to ref_clk_i.
//
// Operation
// - Host filters both short flags for at least 80 us before use.
// - Host times how long a flag stays low and may disable that driver.
// - Host enables the other driver 3 ms before applying its data.
// - After a wake acknowledge, host keeps the aux driver out of loads.
// - Line master resends twice, one cycle time apart, then re-wakes.
// - Wake stays low until enable goes low and transmit bit toggles.
// - Host limits wake reactions when no communication follows them.
// - Link runs at 4.8, 38.4 or 230.4 kb/s; filters scale with it. Here the flag filter stays fixed at FILT_CYC cycles.
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
module lfw_host_ctrl
    import lfw_pkg::*;
#(
    parameter int FILT_CYC  = FLAG_FILT_CYC,
    parameter int LEAD_CYC  = AUX_LEAD_CYC,
    parameter int SHORT_CYC = SHORT_CONFIRM_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [3:0]  avs_byteenable_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        main_short_flag_n_i,
    input  wire logic        aux_short_flag_n_i,
    input  wire logic        wake_flag_n_i,
    input  wire logic        line_rx_bit_i,
    output logic             main_drive_enable_o,
    output logic             aux_drive_enable_o,
    output logic             main_tx_bit_o,
    output logic             aux_tx_bit_o,
    output logic             slew_select_o
);

    // Saturating increment for the wake event counter.
    function automatic logic [3:0] lfw_sat_inc(input logic [3:0] v);
        return (v == 4'hf) ? v : v + 4'h1;
    endfunction

    lfw_filt_if fif ();

    logic [LFW_CTRL_W-1:0] ctrl_ff;
    logic [3:0]            limit_ff;
    logic [3:0]            wake_cnt_ff;
    logic [1:0]            conf_ff;
    logic [LFW_CNT_W-1:0]  short_cnt_ff [2];
    logic [LFW_CNT_W-1:0]  lead_cnt_ff;
    logic [7:0]            step_cnt_ff;
    logic                  aux_ready_ff;
    logic                  hold_ff;
    logic                  wake_d_ff;
    lfw_hs_state_t         hs_ff;
    lfw_hs_state_t         nxt_hs;
    logic [31:0]           rdata_ff;
    logic                  wait_ff;
    logic                  main_en_ff, aux_en_ff, main_tx_ff, aux_tx_ff;
    logic                  slew_ff;

    // Filter the raw flags in the submodule.
    assign fif.ce    = ce_i;
    assign fif.raw_n = {aux_short_flag_n_i, main_short_flag_n_i};

    lfw_flag_filter #(.FILT_CYC(FILT_CYC)) u_filt (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .fif       (fif.flt)
    );

    // Bus decode; a write lands on the edge where waitrequest is seen low.
    wire       wr_go    = avs_write_i & ~wait_ff & avs_byteenable_i[0];
    wire       wr_ctrl  = wr_go & (avs_address_i == LFW_OFS_CTRL);
    wire       wr_limit = wr_go & (avs_address_i == LFW_OFS_LIMIT);
    wire       wr_cmd   = wr_go & (avs_address_i == LFW_OFS_CMD);
    wire       cmd_ack  = wr_cmd & avs_writedata_i[LFW_CMD_ACK];
    wire       cmd_done = wr_cmd & avs_writedata_i[LFW_CMD_START_DONE];
    wire       cmd_ok   = wr_cmd & avs_writedata_i[LFW_CMD_LINK_OK];

    // Flag and wake decode.
    wire [1:0] short_on = ~fif.filt_n;
    wire       thermal  = &short_on;
    wire       wake_on  = ~wake_flag_n_i;
    wire       wake_new = wake_on & ~wake_d_ff;
    wire       limited  = wake_cnt_ff >= limit_ff;
    wire       auto_dis = ctrl_ff[LFW_CTRL_AUTO_DIS];
    wire       ack_req  = wake_on & (cmd_ack |
                          (ctrl_ff[LFW_CTRL_AUTO_ACK] & wake_new & ~limited));
    wire       step_end = step_cnt_ff == 8'(ACK_STEP_CYC - 1);
    wire       lead_end = lead_cnt_ff == LFW_CNT_W'(LEAD_CYC - 1);
    wire       hs_busy  = hs_ff != HS_IDLE;

    // Next pin levels; a handshake overrides the main driver pins.
    wire nxt_main_en = ~hs_busy & ctrl_ff[LFW_CTRL_MAIN_EN] &
                       ~(auto_dis & conf_ff[0]);
    wire nxt_main_tx = (hs_ff == HS_TOGGLE) ? ~ctrl_ff[LFW_CTRL_MAIN_TX]
                                            : ctrl_ff[LFW_CTRL_MAIN_TX];
    wire nxt_aux_en  = ctrl_ff[LFW_CTRL_AUX_EN] & ~hold_ff &
                       ~(auto_dis & conf_ff[1]);
    // Aux data falls with its enable, so it never stands on a driver that
    // a hold or a confirmed short has just switched off.
    wire nxt_aux_tx  = aux_ready_ff & nxt_aux_en &
                       ctrl_ff[LFW_CTRL_AUX_TX];

    // Read data assembly.
    wire [31:0] status_w = {16'h0000, wake_cnt_ff, 1'b0, hs_busy,
                            line_rx_bit_i, limited, hold_ff, aux_ready_ff,
                            wake_on, thermal, conf_ff, short_on};
    wire [31:0] nxt_rdata =
        (avs_address_i == LFW_OFS_CTRL)   ? {25'h0, ctrl_ff}  :
        (avs_address_i == LFW_OFS_STATUS) ? status_w          :
        (avs_address_i == LFW_OFS_LIMIT)  ? {28'h0, limit_ff} : 32'h0;

    // Handshake: drop the enable, toggle the data bit, then restore it.
    always_comb begin
        nxt_hs = hs_ff;
        unique case (hs_ff)
            HS_IDLE:   if (ack_req) nxt_hs = HS_DROP;
            HS_DROP:   if (step_end) nxt_hs = HS_TOGGLE;
            HS_TOGGLE: if (step_end) nxt_hs = HS_IDLE;
        endcase
    end

    // Slave answer: one wait cycle, then data and waitrequest low together.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0;
        end else if (ce_i) begin
            wait_ff  <= ~((avs_read_i | avs_write_i) & wait_ff);
            rdata_ff <= (avs_read_i & wait_ff) ? nxt_rdata : rdata_ff;
        end
    end

    // Software registers; a hardware set of the hold beats a clear.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff  <= LFW_CTRL_RST;
            limit_ff <= LFW_LIMIT_RST;
            hold_ff  <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctrl) ctrl_ff <= avs_writedata_i[LFW_CTRL_W-1:0];
            if (wr_limit) limit_ff <= avs_writedata_i[3:0];
            if (hs_ff == HS_TOGGLE && step_end) begin
                hold_ff <= 1'b1;
            end else if (cmd_done) begin
                hold_ff <= 1'b0;
            end
        end
    end

    // Wake counting; link success clears it unless a wake lands now.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_d_ff   <= 1'b0;
            wake_cnt_ff <= 4'h0;
        end else if (ce_i) begin
            wake_d_ff <= wake_on;
            if (wake_new) begin
                wake_cnt_ff <= lfw_sat_inc(wake_cnt_ff);
            end else if (cmd_ok) begin
                wake_cnt_ff <= 4'h0;
            end
        end
    end

    // Handshake state and its step timer.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hs_ff       <= HS_IDLE;
            step_cnt_ff <= 8'h00;
        end else if (ce_i) begin
            hs_ff       <= nxt_hs;
            step_cnt_ff <= (nxt_hs != hs_ff || !hs_busy) ? 8'h00
                                                         : step_cnt_ff + 8'h01;
        end
    end

    // Short timing per driver; thermal shutdown is not counted as a short,
    // so a hot die never latches a driver off by itself.
    for (genvar c = 0; c < 2; c++) begin : g_short
        wire run = short_on[c] & ~thermal;
        wire hit = short_cnt_ff[c] == LFW_CNT_W'(SHORT_CYC - 1);
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                short_cnt_ff[c] <= '0;
                conf_ff[c]      <= 1'b0;
            end else if (ce_i) begin
                short_cnt_ff[c] <= (run && !hit) ? short_cnt_ff[c] + 1'b1
                                                 : '0;
                if (run && hit) begin
                    conf_ff[c] <= 1'b1;
                end else if (cmd_ok) begin
                    conf_ff[c] <= 1'b0;
                end
            end
        end
    end

    // Aux lead timer: data waits until the driver has been on long enough.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lead_cnt_ff  <= '0;
            aux_ready_ff <= 1'b0;
        end else if (ce_i) begin
            if (!aux_en_ff) begin
                lead_cnt_ff  <= '0;
                aux_ready_ff <= 1'b0;
            end else if (!aux_ready_ff) begin
                lead_cnt_ff  <= lead_cnt_ff + 1'b1;
                aux_ready_ff <= lead_end;
            end
        end
    end

    // Pin flip-flops.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            main_en_ff <= 1'b0;
            aux_en_ff  <= 1'b0;
            main_tx_ff <= 1'b0;
            aux_tx_ff  <= 1'b0;
            slew_ff    <= 1'b0;
        end else if (ce_i) begin
            main_en_ff <= nxt_main_en;
            aux_en_ff  <= nxt_aux_en;
            main_tx_ff <= nxt_main_tx;
            aux_tx_ff  <= nxt_aux_tx;
            slew_ff    <= ctrl_ff[LFW_CTRL_SLEW];
        end
    end

    assign avs_readdata_o      = rdata_ff;
    assign avs_waitrequest_o   = wait_ff;
    assign main_drive_enable_o = main_en_ff;
    assign aux_drive_enable_o  = aux_en_ff;
    assign main_tx_bit_o       = main_tx_ff;
    assign aux_tx_bit_o        = aux_tx_ff;
    assign slew_select_o       = slew_ff;

    property p_aux_lead;
        @(posedge ref_clk_i) disable iff (rst_i)
        aux_tx_bit_o |-> aux_drive_enable_o && $past(aux_ready_ff);
    endproperty
    a_aux_lead: assert property (p_aux_lead)
        else $error("Aux data applied before the lead time.");

    property p_lead_count;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(aux_ready_ff) |-> $past(lead_cnt_ff) == LFW_CNT_W'(LEAD_CYC - 1);
    endproperty
    a_lead_count: assert property (p_lead_count)
        else $error("Aux ready raised at the wrong count.");

    property p_hold_aux;
        @(posedge ref_clk_i) disable iff (rst_i || !ce_i)
        hold_ff |=> !aux_drive_enable_o;
    endproperty
    a_hold_aux: assert property (p_hold_aux)
        else $error("Aux driver enabled during link start-up.");

    property p_hs_toggle;
        @(posedge ref_clk_i) disable iff (rst_i || !ce_i)
        (hs_ff == HS_DROP) ##1 (hs_ff == HS_TOGGLE) |=>
            !main_drive_enable_o && $changed(main_tx_bit_o);
    endproperty
    a_hs_toggle: assert property (p_hs_toggle)
        else $error("Handshake toggled data without enable low.");

    property p_hs_enable;
        @(posedge ref_clk_i) disable iff (rst_i || !ce_i)
        hs_busy |=> !main_drive_enable_o;
    endproperty
    a_hs_enable: assert property (p_hs_enable)
        else $error("Main enable high during the handshake.");

    property p_short_disable;
        @(posedge ref_clk_i) disable iff (rst_i || !ce_i)
        conf_ff[0] && auto_dis |=> !main_drive_enable_o;
    endproperty
    a_short_disable: assert property (p_short_disable)
        else $error("Confirmed short did not disable the main driver.");

    property p_conf_time;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(conf_ff[1]) |-> $past(short_cnt_ff[1]) ==
            LFW_CNT_W'(SHORT_CYC - 1) && $past(short_on[1]);
    endproperty
    a_conf_time: assert property (p_conf_time)
        else $error("Short confirmed before the timing limit.");

    property p_limit;
        @(posedge ref_clk_i) disable iff (rst_i || !ce_i)
        wake_new && limited && !cmd_ack && !hs_busy |=> hs_ff == HS_IDLE;
    endproperty
    a_limit: assert property (p_limit)
        else $error("Wake acknowledged beyond the event limit.");

    property p_bus_answer;
        @(posedge ref_clk_i) disable iff (rst_i || !ce_i)
        (avs_read_i || avs_write_i) && wait_ff |=> !avs_waitrequest_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Bus answer missing after one wait cycle.");

    c_handshake: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        hs_ff == HS_TOGGLE ##1 hs_ff == HS_IDLE);
    c_confirm: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(conf_ff[0]));
    c_thermal: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(thermal));
    c_aux_ready: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(aux_ready_ff));

endmodule

// ---- sim/lfw_dev_model.sv ----
// Behavioural model of the two-driver line transceiver seen by the host.
// Assumes the bench steers faults, heat and the far master through inputs.
module lfw_dev_model #(
    parameter int WAKE_CYC = 7500
) (
    input  wire logic ref_clk_i,
    input  wire logic dev_rst_i,
    input  wire logic main_en_i,
    input  wire logic aux_en_i,
    input  wire logic main_tx_i,
    input  wire logic slew_i,
    input  wire logic main_fault_i,
    input  wire logic aux_fault_i,
    input  wire logic hot_i,
    input  wire logic master_hi_i,
    output logic      main_short_n_o,
    output logic      aux_short_n_o,
    output logic      wake_n_o,
    output logic      rx_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic line;
    logic opp;
    logic tx_q;
    int   wcnt;
    int   rcnt;
    int   rej;

    // A released line falls to the master's pull-down; heat stops drivers.
    assign line = master_hi_i |
                  (main_en_i & ~hot_i & ~main_tx_i);
    assign opp  = main_en_i ? (line == main_tx_i) : line;
    // Open-collector flags read high once released by the device.
    assign main_short_n_o = ~(hot_i |
                              (main_fault_i & main_en_i));
    assign aux_short_n_o  = ~(hot_i |
                              (aux_fault_i & aux_en_i));
    // One sixteenth of a bit at the fast and medium rates.
    assign rej = slew_i ? 28 : 163;

    // The wake timer restarts whenever the overdrive goes away.
    always_ff @(posedge ref_clk_i or posedge dev_rst_i) begin
        if (dev_rst_i) begin
            wake_n_o <= 1'b1;
            wcnt     <= 0;
            tx_q     <= 1'b0;
        end else begin
            tx_q <= main_tx_i;
            wcnt <= !opp ? 0 : (wcnt < WAKE_CYC ? wcnt + 1 : wcnt);
            if (opp && wcnt == WAKE_CYC) begin
                wake_n_o <= 1'b0;
            end else if (!main_en_i && main_tx_i != tx_q) begin
                wake_n_o <= 1'b1;
            end
        end
    end

    // A level change passes only once it has outlived the reject time.
    always_ff @(posedge ref_clk_i or posedge dev_rst_i) begin
        if (dev_rst_i) begin
            rx_o <= 1'b0;
            rcnt <= 0;
        end else if (line == rx_o) begin
            rcnt <= 0;
        end else if (rcnt >= rej) begin
            rx_o <= line;
            rcnt <= 0;
        end else begin
            rcnt <= rcnt + 1;
        end
    end
endmodule

// ---- sim/line_fault_and_wakeup_logic_tb.sv ----
// Self-checking bench for the host controller, bus tasks and scenarios.
// Assumes the device model above stands on the far side of the pins.
module line_fault_and_wakeup_logic_tb
    import lfw_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

`define CHK(g, e) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) begin \
            error_cnt++; \
            $display("wrong value at %0t: got %h, expected %h", \
                     $time, (g), (e)); \
        end \
    end

    localparam int FILT = 4;
    localparam int LEAD = 8;
    localparam int SHRT = 16;
    localparam int WAKE = 7500;

    logic        ref_clk, rst, av_read, av_write;
    logic [3:0]  av_addr, av_be;
    logic [31:0] av_wdata, av_rdata, rv;
    logic        av_wait, main_en, aux_en, main_tx, aux_tx, slew;
    logic        main_sc_n, aux_sc_n, wake_n, rx;
    logic        dev_rst, main_fault, aux_fault, hot, master_hi, ce;
    int          error_cnt, samples_checked;

    lfw_host_ctrl #(.FILT_CYC(FILT), .LEAD_CYC(LEAD), .SHORT_CYC(SHRT)) dut (
        .ref_clk_i(ref_clk), .rst_i(rst), .ce_i(ce),
        .avs_address_i(av_addr), .avs_read_i(av_read),
        .avs_write_i(av_write), .avs_byteenable_i(av_be),
        .avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata),
        .avs_waitrequest_o(av_wait), .main_short_flag_n_i(main_sc_n),
        .aux_short_flag_n_i(aux_sc_n), .wake_flag_n_i(wake_n),
        .line_rx_bit_i(rx), .main_drive_enable_o(main_en),
        .aux_drive_enable_o(aux_en), .main_tx_bit_o(main_tx),
        .aux_tx_bit_o(aux_tx), .slew_select_o(slew));

    lfw_dev_model #(.WAKE_CYC(WAKE)) dev (
        .ref_clk_i(ref_clk), .dev_rst_i(dev_rst), .main_en_i(main_en),
        .aux_en_i(aux_en), .main_tx_i(main_tx), .slew_i(slew),
        .main_fault_i(main_fault), .aux_fault_i(aux_fault), .hot_i(hot),
        .master_hi_i(master_hi), .main_short_n_o(main_sc_n),
        .aux_short_n_o(aux_sc_n), .wake_n_o(wake_n), .rx_o(rx));

    // Free-running block clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One Avalon access; held until waitrequest is sampled low. Only the
    // watchdog ends a wait for an answer that never comes.
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        av_read  <= ~w;
        av_write <= w;
        av_addr  <= a;
        av_wdata <= d;
        av_be    <= be;
        do begin
            @(posedge ref_clk);
        end while (av_wait !== 1'b0);
        rv = av_rdata;
        av_read  <= 1'b0;
        av_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        `CHK(rv & m, e)
    endtask

    task automatic complete_run;
        $display("errors %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The tests need about 25,000 cycles; a hung wait ends as a failure.
    initial begin
        wt(40000);
        error_cnt++;
        complete_run;
    end

    // Main sequence: reset, bus corners, shorts, heat, wake handling.
    initial begin
        {rst, dev_rst, ce} = 3'h7;
        {av_read, av_write, av_addr, av_be, av_wdata} = '0;
        {main_fault, aux_fault, hot, master_hi} = '0;
        error_cnt = 0;
        samples_checked = 0;
        wt(3);
        rst <= 1'b0;
        dev_rst <= 1'b0;
        wt(1);
        `CHK({main_en, aux_en, main_tx, aux_tx, slew}, 5'h00)
        rd(LFW_OFS_CTRL, 32'h7f, {25'h0, LFW_CTRL_RST});
        rd(LFW_OFS_LIMIT, 32'hf, {28'h0, LFW_LIMIT_RST});
        rd(4'h2, 32'hffffffff, 32'h0);
        bus(1'b1, LFW_OFS_LIMIT, 32'h1, 4'h0);
        rd(LFW_OFS_LIMIT, 32'hf, 32'h3);
        // Aux data is held back until its driver has led by the lead time.
        wr(LFW_OFS_CTRL, 32'h1b);
        wt(3);
        `CHK({main_en, aux_en, slew, aux_tx}, 4'he)
        // With the clock enable low the lead count must not advance.
        ce <= 1'b0;
        wt(LEAD + 4);
        `CHK(aux_tx, 1'b0)
        ce <= 1'b1;
        wt(LEAD + 4);
        `CHK(aux_tx, 1'b1)
        // A reflection shorter than the filter must never reach status.
        main_fault <= 1'b1;
        wt(FILT - 2);
        main_fault <= 1'b0;
        wt(FILT + 4);
        rd(LFW_OFS_STATUS, 32'hf, 32'h0);
        main_fault <= 1'b1;
        wt(FILT + 4);
        rd(LFW_OFS_STATUS, 32'hf, 32'h1);
        wt(SHRT + 4);
        rd(LFW_OFS_STATUS, 32'hf, 32'h5);
        wr(LFW_OFS_CTRL, 32'h3b);
        wt(3);
        `CHK({main_en, aux_en}, 2'b01)
        wt(FILT + 4);
        rd(LFW_OFS_STATUS, 32'hf, 32'h4);
        wr(LFW_OFS_CMD, 32'h4);
        main_fault <= 1'b0;
        wt(2);
        rd(LFW_OFS_STATUS, 32'hf, 32'h0);
        // Heat flags both channels with enables low and is never confirmed.
        wr(LFW_OFS_CTRL, 32'h0);
        hot <= 1'b1;
        wt(FILT + 4);
        rd(LFW_OFS_STATUS, 32'h1f, 32'h13);
        wt(SHRT + 8);
        rd(LFW_OFS_STATUS, 32'h1f, 32'h13);
        hot <= 1'b0;
        // Wake with the main driver off, acknowledged by command.
        master_hi <= 1'b1;
        wt(WAKE + 20);
        rd(LFW_OFS_STATUS, 32'hf2e0, 32'h1220);
        master_hi <= 1'b0;
        wr(LFW_OFS_CMD, 32'h1);
        wt(ACK_STEP_CYC + 10);
        `CHK({main_en, main_tx}, 2'b01)
        wt(ACK_STEP_CYC + 40);
        wr(LFW_OFS_CTRL, 32'h2);
        wt(3);
        `CHK(aux_en, 1'b0)
        rd(LFW_OFS_STATUS, 32'h4a0, 32'h080);
        wr(LFW_OFS_CMD, 32'h2);
        wt(3);
        `CHK(aux_en, 1'b1)
        // Past the reaction limit a wake is left for software.
        wr(LFW_OFS_LIMIT, 32'h1);
        wr(LFW_OFS_CTRL, 32'h47);
        master_hi <= 1'b1;
        aux_fault <= 1'b1;
        wt(WAKE + 20);
        master_hi <= 1'b0;
        wt(ACK_STEP_CYC);
        `CHK(main_en, 1'b1)
        rd(LFW_OFS_STATUS, 32'hf12f, 32'h212a);
        aux_fault <= 1'b0;
        dev_rst <= 1'b1;
        wt(1);
        dev_rst <= 1'b0;
        wt(3);
        rd(LFW_OFS_STATUS, 32'h20, 32'h0);
        // After good traffic the count restarts and auto-ack fires again.
        wr(LFW_OFS_CMD, 32'h4);
        rd(LFW_OFS_STATUS, 32'hf000, 32'h0);
        master_hi <= 1'b1;
        wt(WAKE + 20);
        `CHK(main_en, 1'b0)
        master_hi <= 1'b0;
        wt(2 * ACK_STEP_CYC + 50);
        rd(LFW_OFS_STATUS, 32'hf0a0, 32'h1080);
        complete_run;
    end
endmodule
